// [pcp_pkg.sv]
/*
 * Shared constants and types of the program control core: register map,
 * status and stack pointer layouts, opcodes and one-hot states.
 * Assumes a 32-bit register bus with byte addresses on word boundaries.
 */
`default_nettype none

package pcp_pkg;

	// ************************************************
	// Widths
	// ************************************************

	// Instruction word width.
	localparam int INSN_W = 24;
	// Width of one stack half and of the address registers.
	localparam int HALF_W = 16;
	// Register bus data and address width.
	localparam int WORD_W = 32;
	localparam int ADDR_W = 8;
	// Entries of the system stack.
	localparam int STACK_DEPTH = 15;
	// Implemented bits of the stack pointer register.
	localparam int SP_FIELD_W = 6;

	// ************************************************
	// Register map (byte offsets)
	// ************************************************

	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_SPTR = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_SSH = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_SSL = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_LA = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_LC = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_PC = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_STATE = 8'h1c;
	// Register indices; IDX_NONE marks an unmapped address.
	localparam logic [3:0] IDX_STATUS = 4'h0;
	localparam logic [3:0] IDX_SPTR = 4'h1;
	localparam logic [3:0] IDX_SSH = 4'h2;
	localparam logic [3:0] IDX_SSL = 4'h3;
	localparam logic [3:0] IDX_LA = 4'h4;
	localparam logic [3:0] IDX_LC = 4'h5;
	localparam logic [3:0] IDX_PC = 4'h6;
	localparam logic [3:0] IDX_STATE = 4'h7;
	localparam logic [3:0] IDX_NONE = 4'h8;

	// ************************************************
	// Status word layout
	// ************************************************

	localparam int SR_C = 0;
	localparam int SR_V = 1;
	localparam int SR_Z = 2;
	localparam int SR_N = 3;
	localparam int SR_U = 4;
	localparam int SR_E = 5;
	localparam int SR_L = 6;
	localparam int SR_S = 7;
	localparam int SR_I0 = 8;
	localparam int SR_I1 = 9;
	localparam int SR_S0 = 10;
	localparam int SR_S1 = 11;
	localparam int SR_RSV = 12;
	localparam int SR_T = 13;
	localparam int SR_LF = 15;
	// Bits 12 and 14 are reserved and always read as zero.
	localparam logic [15:0] SR_IMPL_MASK = 16'hafff;
	// Masks at top level after reset.
	localparam logic [15:0] SR_RESET = 16'h0300;

	// ************************************************
	// Stack pointer layout and other values
	// ************************************************

	localparam int SP_ERR_BIT = 4;
	localparam int SP_UF_BIT = 5;
	localparam logic [3:0] SP_EMPTY = 4'h0;
	localparam logic [3:0] SP_FULL = 4'hf;
	localparam logic [1:0] IPL_NMI = 2'h3;
	localparam logic [15:0] LC_ONE = 16'h0001;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Instruction fields.
	localparam int OPC_LSB = 20;
	localparam int DO_CNT_LSB = 12;

	// ************************************************
	// Types
	// ************************************************

	// Control opcodes; every other code goes to the execution units.
	typedef enum logic [3:0] {
		OP_NOP = 4'h0,
		OP_JUMP = 4'h1,
		OP_CALL = 4'h2,
		OP_RET = 4'h3,
		OP_DO = 4'h4,
		OP_REP = 4'h5,
		OP_WAIT = 4'h6,
		OP_STOP = 4'h7,
		OP_EXEC = 4'h8
	} pcp_op_t;

	// Processing states, one-hot.
	typedef enum logic [4:0] {
		ST_RESET = 5'h01,
		ST_NORMAL = 5'h02,
		ST_EXCEPT = 5'h04,
		ST_WAIT = 5'h08,
		ST_STOP = 5'h10
	} pcp_state_t;

	// Multi-cycle stack sequences, one-hot.
	typedef enum logic [3:0] {
		SQ_IDLE = 4'h1,
		SQ_DO2 = 4'h2,
		SQ_LEND1 = 4'h4,
		SQ_LEND2 = 4'h8
	} pcp_seq_t;

endpackage

`default_nettype wire

// [pcp_stack.sv]
/*
 * Hardware system stack with its pointer, error and underflow flags.
 * Assumes the caller never asks for push and pop in the same cycle.
 */
`default_nettype none

module pcp_stack (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Push and pop from the sequencer.
	input wire logic push,
	input wire logic pop,
	input wire logic [pcp_pkg::WORD_W-1:0] push_data,
	// Direct register writes.
	input wire logic sp_wr,
	input wire logic [pcp_pkg::SP_FIELD_W-1:0] sp_wdata,
	input wire logic hi_wr,
	input wire logic lo_wr,
	input wire logic [pcp_pkg::HALF_W-1:0] half_wdata,
	// Entry under the pointer and the pointer register.
	output logic [pcp_pkg::WORD_W-1:0] top_data,
	output logic [pcp_pkg::SP_FIELD_W-1:0] sp_field
);
	import pcp_pkg::*;

	// ************************************************
	// State
	// ************************************************

	typedef struct packed {
		logic [STACK_DEPTH-1:0][WORD_W-1:0] mem;
		logic [3:0] ptr;
		logic err;
		logic uf;
	} pcp_stack_st_t;

	pcp_stack_st_t r_reg;
	pcp_stack_st_t r_next;
	// Entry slot of the pointer; pointer zero means empty.
	logic [3:0] slot;

	assign slot = r_reg.ptr - 4'h1;
	assign top_data = (r_reg.ptr == SP_EMPTY) ? '0 : r_reg.mem[slot];
	assign sp_field = {r_reg.uf, r_reg.err, r_reg.ptr};

	// Next state. Flags set by push or pop win over a clearing write.
	always_comb begin
		r_next = r_reg;
		if (sp_wr) begin
			r_next.ptr = sp_wdata[3:0];
			r_next.err = sp_wdata[SP_ERR_BIT];
			r_next.uf = sp_wdata[SP_UF_BIT];
		end
		if (r_reg.ptr != SP_EMPTY && hi_wr) begin
			r_next.mem[slot][WORD_W-1:HALF_W] = half_wdata;
		end
		if (r_reg.ptr != SP_EMPTY && lo_wr) begin
			r_next.mem[slot][HALF_W-1:0] = half_wdata;
		end
		if (push) begin
			if (r_reg.ptr == SP_FULL) begin
				r_next.err = 1'b1;
			end else begin
				r_next.ptr = r_reg.ptr + 4'h1;
				r_next.mem[r_reg.ptr] = push_data;
			end
		end else if (pop) begin
			if (r_reg.ptr == SP_EMPTY) begin
				r_next.err = 1'b1;
				r_next.uf = 1'b1;
			end else begin
				r_next.ptr = r_reg.ptr - 4'h1;
			end
		end
	end

	// State register; the entries themselves are cleared too.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

endmodule

`default_nettype wire

// [pcp_decode.sv]
/*
 * Instruction decoder: splits a 24-bit word into a control opcode and
 * its operand fields. Purely combinational.
 */
`default_nettype none

module pcp_decode (
	// Word from the instruction or backup latch.
	input wire logic [pcp_pkg::INSN_W-1:0] insn,
	// Decoded fields.
	output pcp_pkg::pcp_op_t op,
	output logic [pcp_pkg::HALF_W-1:0] target,
	output logic [pcp_pkg::HALF_W-1:0] count
);
	import pcp_pkg::*;

	always_comb begin
		op = OP_EXEC;
		target = insn[HALF_W-1:0];
		count = insn[HALF_W-1:0];
		unique case (insn[INSN_W-1:OPC_LSB])
			4'h0: op = OP_NOP;
			4'h1: op = OP_JUMP;
			4'h2: op = OP_CALL;
			4'h3: op = OP_RET;
			4'h4: begin
				// Loop: 8-bit count above a 12-bit last address.
				op = OP_DO;
				target = {4'h0, insn[DO_CNT_LSB-1:0]};
				count = {8'h00, insn[OPC_LSB-1:DO_CNT_LSB]};
			end
			4'h5: op = OP_REP;
			4'h6: op = OP_WAIT;
			4'h7: op = OP_STOP;
			default: op = OP_EXEC;
		endcase
	end

endmodule

`default_nettype wire

// [pcp_core.sv]
/*
 * Program control core: three-stage fetch/decode/execute pipeline, loop
 * and repeat control, processing states, and AXI4-Lite register access.
 * Assumes program memory answers fetch_req with fetch_valid and that the
 * execution units take exe_insn on each exe_valid pulse.
 */
`default_nettype none

// Function
// - Fifteen-entry 32-bit internal system stack.
// - Stack saves counter, status, loop registers.
// - Each entry has high and low halves.
// - Pointer selects entry for all accesses.
// - All control registers readable; all but the state register writable.
// - Reads zero the unused upper bits.
// - Writes keep only implemented low bits.
// - Fetch, decode, execute overlap each cycle.
// - Five states: normal, exception, reset, wait, stop.
// - Decoder steers pipeline from instruction latch.
// - Backup latch lets repeat skip refetch.
// - Loop address and count registers exist.
// - Condition bits sit in status bits 0-6.
// - Mask, scaling, trace, loop flag placement.
// - Pointer, error, underflow in pointer register.
// - Loop end decrements or restores loop state.
// - Loop start pushes loop registers and status.
// - Mask bits hold level; level three unmaskable.
// - Reserved bits read zero, written zero.
module pcp_core #(
	parameter logic [15:0] RESET_PC = 16'h0000
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write channels.
	input wire logic [pcp_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [pcp_pkg::WORD_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read channels.
	input wire logic [pcp_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [pcp_pkg::WORD_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Program memory fetch.
	output logic fetch_req,
	output logic [pcp_pkg::HALF_W-1:0] fetch_addr,
	input wire logic fetch_valid,
	input wire logic [pcp_pkg::INSN_W-1:0] fetch_data,
	// Execution units.
	output logic exe_valid,
	output logic [pcp_pkg::INSN_W-1:0] exe_insn,
	// Interrupt request and acknowledge.
	input wire logic irq_req,
	input wire logic [1:0] irq_level,
	input wire logic [pcp_pkg::HALF_W-1:0] irq_vector,
	output logic irq_ack,
	// Processing state, one-hot.
	output logic [4:0] proc_state
);
	import pcp_pkg::*;

	// ************************************************
	// State and local signals
	// ************************************************

	// All state of the core in one record.
	typedef struct packed {
		pcp_state_t state;
		pcp_seq_t seq;
		logic [15:0] pc;
		logic [15:0] sr;
		logic [15:0] la;
		logic [15:0] lc;
		logic [15:0] lp_top;
		logic [1:0] ipl;
		logic il_v;
		logic [INSN_W-1:0] il_insn;
		logic [15:0] il_pc;
		logic [INSN_W-1:0] bk_insn;
		logic rep_act;
		logic ex_v;
		logic ex_new;
		logic [INSN_W-1:0] ex_insn;
		pcp_op_t ex_op;
		logic [15:0] ex_pc;
		logic [15:0] ex_tgt;
		logic [15:0] ex_cnt;
		logic fetch_req;
		logic irq_ack;
		logic aw_v;
		logic [ADDR_W-1:0] aw_addr;
		logic w_v;
		logic [WORD_W-1:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic arready;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [WORD_W-1:0] rdata;
		logic [1:0] rresp;
	} pcp_core_st_t;

	pcp_core_st_t r_reg;
	pcp_core_st_t r_next;
	// Stack port drives, produced by the sequencer below.
	logic st_push;
	logic st_pop;
	logic [WORD_W-1:0] st_pdata;
	logic sp_wr;
	logic hi_wr;
	logic lo_wr;
	logic [WORD_W-1:0] top_data;
	logic [SP_FIELD_W-1:0] sp_field;
	// Decoder view of the word that moves into execute.
	logic [INSN_W-1:0] dec_in;
	pcp_op_t dec_op;
	logic [15:0] dec_tgt;
	logic [15:0] dec_cnt;
	// Pipeline control terms.
	logic take;
	logic run;
	logic reissue;
	logic adv;
	// Readback values by register index.
	logic [WORD_W-1:0] rd_arr [0:7];
	// Write data after byte strobes and the register index of the write.
	logic [WORD_W-1:0] wmerged;
	logic [3:0] widx;

	// Maps a byte address to a register index, shared by reads and writes.
	function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] a);
		unique case (a)
			OFF_STATUS: reg_index = IDX_STATUS;
			OFF_SPTR: reg_index = IDX_SPTR;
			OFF_SSH: reg_index = IDX_SSH;
			OFF_SSL: reg_index = IDX_SSL;
			OFF_LA: reg_index = IDX_LA;
			OFF_LC: reg_index = IDX_LC;
			OFF_PC: reg_index = IDX_PC;
			OFF_STATE: reg_index = IDX_STATE;
			default: reg_index = IDX_NONE;
		endcase
	endfunction

	// ************************************************
	// Submodules
	// ************************************************

	pcp_stack u_stack (
		.aclk(aclk),
		.aresetn(aresetn),
		.push(st_push),
		.pop(st_pop),
		.push_data(st_pdata),
		.sp_wr(sp_wr),
		.sp_wdata(wmerged[SP_FIELD_W-1:0]),
		.hi_wr(hi_wr),
		.lo_wr(lo_wr),
		.half_wdata(wmerged[HALF_W-1:0]),
		.top_data(top_data),
		.sp_field(sp_field)
	);

	assign dec_in = reissue ? r_reg.bk_insn : r_reg.il_insn;

	pcp_decode u_decode (
		.insn(dec_in),
		.op(dec_op),
		.target(dec_tgt),
		.count(dec_cnt)
	);

	// ************************************************
	// Control terms and readback
	// ************************************************

	assign take = irq_req && (irq_level == IPL_NMI || irq_level > r_reg.sr[SR_I1:SR_I0]);
	assign run = r_reg.state == ST_NORMAL && r_reg.seq == SQ_IDLE;
	assign reissue = r_reg.rep_act && r_reg.lc > LC_ONE;
	assign adv = run && (fetch_valid || reissue) && !(take && !r_reg.rep_act);

	assign rd_arr[0] = {16'h0000, r_reg.sr & SR_IMPL_MASK};
	assign rd_arr[1] = {26'h0, sp_field};
	assign rd_arr[2] = {16'h0000, top_data[WORD_W-1:HALF_W]};
	assign rd_arr[3] = {16'h0000, top_data[HALF_W-1:0]};
	assign rd_arr[4] = {16'h0000, r_reg.la};
	assign rd_arr[5] = {16'h0000, r_reg.lc};
	assign rd_arr[6] = {16'h0000, r_reg.pc};
	assign rd_arr[7] = {27'h0, r_reg.state};

	assign widx = reg_index(r_reg.aw_addr);
	// Strobed lanes take new data, the others keep the current value.
	assign wmerged = widx == IDX_NONE ? '0 : (rd_arr[widx[2:0]] & ~{{8{r_reg.w_strb[3]}},
		{8{r_reg.w_strb[2]}}, {8{r_reg.w_strb[1]}}, {8{r_reg.w_strb[0]}}})
		| (r_reg.w_data & {{8{r_reg.w_strb[3]}}, {8{r_reg.w_strb[2]}},
		{8{r_reg.w_strb[1]}}, {8{r_reg.w_strb[0]}}});

	// ************************************************
	// Sequencer, pipeline and bus slave
	// ************************************************

	// Next state of the whole core. Bus writes come last and win, except that a stack push or pop wins over a pointer write.
	always_comb begin
		r_next = r_reg;
		st_push = 1'b0;
		st_pop = 1'b0;
		st_pdata = '0;
		sp_wr = 1'b0;
		hi_wr = 1'b0;
		lo_wr = 1'b0;
		r_next.irq_ack = 1'b0;
		r_next.ex_new = 1'b0;
		unique case (r_reg.state)
			ST_RESET: r_next.state = ST_NORMAL;
			ST_NORMAL: begin
				if (run && take && !r_reg.rep_act) begin
					// Drop the pipeline and resume at its oldest word.
					r_next.state = ST_EXCEPT;
					r_next.ipl = irq_level;
					r_next.il_pc = r_reg.ex_v ? r_reg.ex_pc : (r_reg.il_v ? r_reg.il_pc : r_reg.pc);
					r_next.il_v = 1'b0;
					r_next.ex_v = 1'b0;
				end else if (adv) begin
					r_next.ex_v = r_reg.il_v;
					r_next.ex_new = r_reg.il_v;
					r_next.ex_insn = dec_in;
					r_next.ex_op = dec_op;
					r_next.ex_tgt = dec_tgt;
					r_next.ex_cnt = dec_cnt;
					r_next.ex_pc = r_reg.il_pc;
					if (reissue) begin
						r_next.lc = r_reg.lc - LC_ONE;
					end else begin
						r_next.rep_act = 1'b0;
						r_next.il_v = 1'b1;
						r_next.il_insn = fetch_data;
						r_next.il_pc = r_reg.pc;
						r_next.bk_insn = r_reg.il_insn;
						r_next.pc = r_reg.pc + 16'h0001;
						if (r_reg.sr[SR_LF] && r_reg.pc == r_reg.la) begin
							if (r_reg.lc != LC_ONE) begin
								r_next.lc = r_reg.lc - LC_ONE;
								r_next.pc = top_data[WORD_W-1:HALF_W];
							end else begin
								r_next.seq = SQ_LEND1;
							end
						end
					end
					if (r_reg.ex_v) begin
						unique case (r_reg.ex_op)
							OP_JUMP, OP_CALL: begin
								st_push = r_reg.ex_op == OP_CALL;
								st_pdata = {r_reg.ex_pc + 16'h0001, r_reg.sr};
								r_next.pc = r_reg.ex_tgt;
								r_next.il_v = 1'b0;
								r_next.ex_v = 1'b0;
								r_next.ex_new = 1'b0;
							end
							OP_RET: begin
								st_pop = 1'b1;
								r_next.pc = top_data[WORD_W-1:HALF_W];
								r_next.sr = top_data[HALF_W-1:0] & SR_IMPL_MASK;
								r_next.il_v = 1'b0;
								r_next.ex_v = 1'b0;
								r_next.ex_new = 1'b0;
							end
							OP_DO: begin
								st_push = 1'b1;
								st_pdata = {r_reg.la, r_reg.lc};
								r_next.la = r_reg.ex_tgt;
								r_next.lc = r_reg.ex_cnt;
								r_next.lp_top = r_reg.ex_pc + 16'h0001;
								r_next.seq = SQ_DO2;
							end
							OP_REP: begin
								r_next.lc = r_reg.ex_cnt;
								r_next.rep_act = r_reg.ex_cnt > LC_ONE;
							end
							OP_WAIT: r_next.state = ST_WAIT;
							OP_STOP: r_next.state = ST_STOP;
							OP_NOP, OP_EXEC: ;
						endcase
					end
				end
				unique case (r_reg.seq)
					SQ_DO2: begin
						st_push = 1'b1;
						st_pdata = {r_reg.lp_top, r_reg.sr};
						r_next.sr[SR_LF] = 1'b1;
						r_next.seq = SQ_IDLE;
					end
					SQ_LEND1: begin
						st_pop = 1'b1;
						r_next.sr[SR_LF] = top_data[SR_LF];
						r_next.seq = SQ_LEND2;
					end
					SQ_LEND2: begin
						st_pop = 1'b1;
						r_next.la = top_data[WORD_W-1:HALF_W];
						r_next.lc = top_data[HALF_W-1:0];
						r_next.seq = SQ_IDLE;
					end
					SQ_IDLE: ;
				endcase
			end
			ST_EXCEPT: begin
				// Long interrupt: save resume address and status.
				st_push = 1'b1;
				st_pdata = {r_reg.il_pc, r_reg.sr};
				r_next.pc = irq_vector;
				r_next.sr[SR_I1:SR_I0] = r_reg.ipl;
				r_next.irq_ack = 1'b1;
				r_next.state = ST_NORMAL;
			end
			ST_WAIT, ST_STOP: begin
				if (take) begin
					r_next.ipl = irq_level;
					r_next.il_pc = r_reg.ex_v ? r_reg.ex_pc : (r_reg.il_v ? r_reg.il_pc : r_reg.pc);
					r_next.il_v = 1'b0;
					r_next.ex_v = 1'b0;
					r_next.state = ST_EXCEPT;
				end
			end
			default: r_next.state = ST_RESET;
		endcase
		// Bus answers are released on their handshakes.
		if (r_reg.bvalid && bready) begin
			r_next.bvalid = 1'b0;
		end
		if (r_reg.rvalid && rready) begin
			r_next.rvalid = 1'b0;
		end
		// Address and data are caught separately, in either order.
		if (awvalid && r_reg.awready) begin
			r_next.aw_v = 1'b1;
			r_next.aw_addr = awaddr;
		end
		if (wvalid && r_reg.wready) begin
			r_next.w_v = 1'b1;
			r_next.w_data = wdata;
			r_next.w_strb = wstrb;
		end
		if (r_reg.aw_v && r_reg.w_v && !r_reg.bvalid) begin
			r_next.aw_v = 1'b0;
			r_next.w_v = 1'b0;
			r_next.bvalid = 1'b1;
			r_next.bresp = widx == IDX_NONE ? RESP_SLVERR : RESP_OKAY;
			unique case (widx)
				IDX_STATUS: r_next.sr = wmerged[HALF_W-1:0] & SR_IMPL_MASK;
				IDX_SPTR: sp_wr = 1'b1;
				IDX_SSH: hi_wr = 1'b1;
				IDX_SSL: lo_wr = 1'b1;
				IDX_LA: r_next.la = wmerged[HALF_W-1:0];
				IDX_LC: r_next.lc = wmerged[HALF_W-1:0];
				IDX_PC: begin
					// A new counter restarts fetch from it.
					r_next.pc = wmerged[HALF_W-1:0];
					r_next.il_v = 1'b0;
					r_next.ex_v = 1'b0;
				end
				default: ;
			endcase
		end
		if (arvalid && r_reg.arready) begin
			r_next.rvalid = 1'b1;
			r_next.rresp = reg_index(araddr) == IDX_NONE ? RESP_SLVERR : RESP_OKAY;
			r_next.rdata = reg_index(araddr) == IDX_NONE ? '0 : rd_arr[3'(reg_index(araddr))];
		end
		// One write and one read in flight at most.
		r_next.awready = !r_next.aw_v && !r_next.bvalid;
		r_next.wready = !r_next.w_v && !r_next.bvalid;
		r_next.arready = !r_next.rvalid;
		r_next.fetch_req = r_next.state == ST_NORMAL && r_next.seq == SQ_IDLE
			&& !(r_next.rep_act && r_next.lc > LC_ONE);
	end

	// State register with synchronous reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_reg <= '0;
			r_reg.state <= ST_RESET;
			r_reg.seq <= SQ_IDLE;
			r_reg.ex_op <= OP_NOP;
			r_reg.pc <= RESET_PC;
			r_reg.sr <= SR_RESET;
		end else begin
			r_reg <= r_next;
		end
	end

	// Outputs straight from the state record.
	assign awready = r_reg.awready;
	assign wready = r_reg.wready;
	assign bvalid = r_reg.bvalid;
	assign bresp = r_reg.bresp;
	assign arready = r_reg.arready;
	assign rvalid = r_reg.rvalid;
	assign rdata = r_reg.rdata;
	assign rresp = r_reg.rresp;
	assign fetch_req = r_reg.fetch_req;
	assign fetch_addr = r_reg.pc;
	assign exe_valid = r_reg.ex_new;
	assign exe_insn = r_reg.ex_insn;
	assign irq_ack = r_reg.irq_ack;
	assign proc_state = r_reg.state;

endmodule

`default_nettype wire

// [pcp_checker.sv]
/*
 * Port checker bound to the program control core.
 * Assumes one clock and the synchronous active-low reset.
 */
`default_nettype none

module pcp_checker
	import pcp_pkg::*;
(
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus.
	input wire logic awready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [pcp_pkg::WORD_W-1:0] rdata,
	// Core status.
	input wire logic irq_ack,
	input wire logic [4:0] proc_state
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Bus and state properties
	// ****************************************

	// All properties sample on the core clock.
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_r_lat; arvalid && arready |=> rvalid; endproperty
	a_r_lat: assert property (p_r_lat) else $error("read answer late");
	property p_r_zero; rvalid |-> rdata[31:16] == 16'h0000; endproperty
	a_r_zero: assert property (p_r_zero) else $error("upper read bits set");
	property p_aw_ref; bvalid |-> !awready; endproperty
	a_aw_ref: assert property (p_aw_ref) else $error("address taken early");
	property p_onehot; $onehot(proc_state); endproperty
	a_onehot: assert property (p_onehot) else $error("state not one-hot");
	// The reset check must run while reset is low, so it has no disable.
	property p_rst; disable iff (1'h0) !aresetn |=> proc_state == ST_RESET; endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	property p_ack; irq_ack |=> !irq_ack; endproperty
	a_ack: assert property (p_ack) else $error("acknowledge too long");
endmodule

bind pcp_core pcp_checker chk_u (.aclk(aclk), .aresetn(aresetn), .awready(awready),
	.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
	.rvalid(rvalid), .rready(rready), .rdata(rdata), .irq_ack(irq_ack),
	.proc_state(proc_state));

`default_nettype wire

// [pcp_mem_model.sv]
/*
 * Program memory model on the fetch port of the core.
 * Assumes the bench loads the words and may stall every answer.
 */
`default_nettype none

module pcp_mem_model (
	// Far side stall.
	input wire logic stall,
	// Fetch port.
	input wire logic fetch_req,
	input wire logic [pcp_pkg::HALF_W-1:0] fetch_addr,
	output logic fetch_valid,
	output logic [pcp_pkg::INSN_W-1:0] fetch_data
);
	timeunit 1ns;
	timeprecision 1ps;
	// Words above the array read as no-operation.
	logic [pcp_pkg::INSN_W-1:0] mem [64];
	logic [pcp_pkg::INSN_W-1:0] word;

	// Invalid cycles show the inverse word so stale data never looks good.
	always_comb begin
		word = (fetch_addr < 16'h0040) ? mem[fetch_addr[5:0]] : 24'h000000;
		fetch_valid = fetch_req && !stall;
		fetch_data = fetch_valid ? word : ~word;
	end
endmodule

`default_nettype wire

// [tb_top.sv]
/*
 * Self-checking bench for the program control core.
 * Assumes the memory model and the bound port checker.
 */
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pcp_pkg::*;

	// Rows: address, write value, read value, response.
	localparam logic [73:0] TAB [9] = '{
		{OFF_STATUS, 32'hffffffff, 32'h0000afff, RESP_OKAY},
		{OFF_STATUS, 32'h0000007f, 32'h0000007f, RESP_OKAY},
		{OFF_LA, 32'habcd1234, 32'h00001234, RESP_OKAY},
		{OFF_LC, 32'h00ff5678, 32'h00005678, RESP_OKAY},
		{OFF_SSL, 32'hdeadbeef, 32'h0000beef, RESP_OKAY},
		{OFF_STATE, 32'h0000001f, 32'h00000008, RESP_OKAY},
		{8'h20, 32'h12345678, 32'h00000000, RESP_SLVERR},
		{OFF_SPTR, 32'hffffffcf, 32'h0000000f, RESP_OKAY},
		{OFF_STATUS, 32'h00000200, 32'h00000200, RESP_OKAY}};
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rd_d;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic irq_req = 1'h0, stall = 1'h1;
	logic [1:0] irq_level = 2'h0, bresp, rresp;
	logic [15:0] irq_vector = 16'h0020, fetch_addr;
	logic awready, wready, bvalid, arready, rvalid, fetch_req, fetch_valid, exe_valid, irq_ack;
	logic [23:0] fetch_data, exe_insn;
	logic [4:0] proc_state;
	logic [3:0] wstrb = 4'hf;
	int error_cnt = 0, checks = 0, ack_n = 0, rep_n = 0;

	pcp_core dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_valid(fetch_valid),
		.fetch_data(fetch_data), .exe_valid(exe_valid), .exe_insn(exe_insn),
		.irq_req(irq_req), .irq_level(irq_level), .irq_vector(irq_vector),
		.irq_ack(irq_ack), .proc_state(proc_state));
	pcp_mem_model mem_u (.stall(stall), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
		.fetch_valid(fetch_valid), .fetch_data(fetch_data));

	// ****************************************
	// Tasks
	// ****************************************

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask

	// Both write channels are offered together and released when taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (awready === 1'h1) awvalid <= 1'h0;
			if (wready === 1'h1) wvalid <= 1'h0;
		end while (bvalid !== 1'h1 && n < 100);
		bready <= 1'h0;
		if (n >= 100) error_cnt++;
		chk({30'h0, bresp}, {30'h0, er});
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (arready === 1'h1) arvalid <= 1'h0;
		end while (rvalid !== 1'h1 && n < 100);
		rd_d = rdata;
		rready <= 1'h0;
		if (n >= 100) error_cnt++;
		chk(rd_d, e);
		chk({30'h0, rresp}, {30'h0, er});
	endtask

	task automatic wst(input logic [4:0] s);
		int n;
		n = 0;
		while (proc_state !== s && n < 200) begin
			@(posedge aclk);
			n++;
		end
		chk({27'h0, proc_state}, {27'h0, s});
	endtask

	task automatic finish_test();
		$display("checks %0d, mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ****************************************
	// Clock, watchdog and tests
	// ****************************************

	initial forever #12.5 aclk = ~aclk;

	// Only one request is taken, so the line drops on its acknowledge.
	always @(posedge aclk) begin
		if (irq_ack === 1'h1) begin
			ack_n <= ack_n + 1;
			irq_req <= 1'h0;
		end
		if (exe_valid === 1'h1 && exe_insn === 24'h812345) rep_n <= rep_n + 1;
	end

	initial begin
		repeat (5000) @(posedge aclk);
		error_cnt++;
		$display("[FAIL] %0t ns: watchdog expired", $time);
		finish_test();
	end

	initial begin
		for (int i = 0; i < 64; i++) mem_u.mem[i] = 24'h000000;
		mem_u.mem[0] = {OP_CALL, 20'h00010};
		mem_u.mem[16] = {OP_WAIT, 20'h00000};
		mem_u.mem[32] = {OP_REP, 20'h00003};
		mem_u.mem[33] = 24'h812345;
		mem_u.mem[34] = {OP_STOP, 20'h00000};
		mem_u.mem[35] = 24'h9abcde;
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		// Memory stalls, so the reset values stay put.
		rc(OFF_STATUS, {16'h0, SR_RESET}, RESP_OKAY);
		rc(OFF_SPTR, 32'h0, RESP_OKAY);
		rc(OFF_STATE, 32'h2, RESP_OKAY);
		stall <= 1'h0;
		wst(ST_WAIT);
		rc(OFF_SPTR, 32'h1, RESP_OKAY);
		rc(OFF_SSH, 32'h1, RESP_OKAY);
		rc(OFF_SSL, {16'h0, SR_RESET}, RESP_OKAY);
		$display("test call done");
		foreach (TAB[i]) begin
			wr(TAB[i][73:66], TAB[i][65:34], TAB[i][1:0]);
			rc(TAB[i][73:66], TAB[i][33:2], TAB[i][1:0]);
		end
		wstrb <= 4'h2;
		wr(OFF_LA, 32'h0000ab00, RESP_OKAY);
		wstrb <= 4'hf;
		rc(OFF_LA, 32'h0000ab34, RESP_OKAY);
		$display("test registers done");
		irq_level <= 2'h2;
		irq_req <= 1'h1;
		repeat (20) @(posedge aclk);
		chk({27'h0, proc_state}, {27'h0, ST_WAIT});
		chk(ack_n, 0);
		wr(OFF_STATUS, 32'h00000100, RESP_OKAY);
		wst(ST_STOP);
		chk(ack_n, 1);
		rc(OFF_SPTR, 32'h1f, RESP_OKAY);
		rc(OFF_STATUS, 32'h200, RESP_OKAY);
		rc(OFF_LC, 32'h1, RESP_OKAY);
		chk(rep_n, 3);
		chk({8'h0, exe_insn}, 32'h009abcde);
		$display("test interrupt done");
		finish_test();
	end
endmodule

`default_nettype wire
